// >>> irhp_pkg.sv
/*
 package for the host bus pin control block: mode codes, field positions, reset values.
 assumes a single core clock domain with synchronous active high reset.
*/
package irhp_pkg;

   localparam int MA_W = 15;
   localparam int SA_W = 3;
   localparam logic [2:0] MODE_DIR_DMA = 3'h0;
   localparam logic [2:0] MODE_DIR_SHM = 3'h1;
   localparam logic [2:0] MODE_IND_DMA = 3'h2;
   localparam logic [2:0] MODE_IND_SHM = 3'h3;
   localparam logic [2:0] MODE_PNP_DMA = 3'h4;
   localparam logic [2:0] MODE_PNP_SHM = 3'h6;
   // address bits tristated in host dma mode: 10..8 and 3..0
   localparam logic [14:0] MA_DMA_TRI_MASK = 15'h070F;
   // address bits 7..4 leave on the dma acknowledge pins in shared memory mode
   localparam int ACK_LO = 4;
   localparam int ACK_HI = 7;
   localparam logic [14:0] MA_RST = 15'h0000;
   localparam logic [2:0] CFG_IDX_RST = 3'h0;

   typedef enum logic [1:0] {
      IRHP_CFG_DIRECT,
      IRHP_CFG_INDIRECT,
      IRHP_CFG_PNP,
      IRHP_CFG_RESERVED
   } irhp_cfg_e;

   // host bus cycle as seen on the pins
   typedef struct packed {
      logic io_access;       // host processor i/o cycle to this device
      logic io_read;         // that cycle is a read
      logic dma_access;      // host dma cycle to this device
      logic dma_read;        // that dma cycle reads the fir controller
      logic mem_window_hit;  // memory address falls in the sram window
      logic [2:0] addr_lo;   // low host address bits
   } irhp_cycle_s;

   // decoded operating mode
   typedef struct packed {
      irhp_cfg_e cfg;
      logic shared_mem;
      logic host_dma;
   } irhp_mode_s;

endpackage

// >>> irhp_pin_ctrl.sv
/*
 host bus pin control: data buffer enable and direction, shared memory address pins,
 memory strobes, dual purpose irq/setup pin and external power down request.
 assumes all pins synchronous to core_clk; mode pins are straps, stable while running.
*/
`timescale 1ns/1ps

// What this block does
// - active-low enable for external data drivers
// - enable on host or host-dma-mode dma access
// - enable on host sram access in shared mode
// - host-dma mode tristates address bits 3:0,10:8
// - memory read strobe honoured only in shared mode
// - memory write strobe used only in shared mode
// - setup pin always in direct; pnp makes irq
// - indirect mode: advanced setting picks pin function
// - accept active-low external power down request
// - direction active on host i/o reads, dma reads in host-dma mode and sram reads
// - shared mode drives address 7:4 on ack pins
// - mode from three select inputs; two reserved
module irhp_pin_ctrl #(
   parameter int MA_WIDTH = irhp_pkg::MA_W
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [2:0] bus_config_select,
   input wire irhp_pkg::irhp_cycle_s host_cycle,
   input wire logic host_mem_read_n,
   input wire logic host_mem_write_n,
   input wire logic [MA_WIDTH-1:0] sram_addr,
   input wire logic irq_or_cfg_select_pin_in,
   output logic irq_or_cfg_select_pin_out,
   output logic irq_or_cfg_select_pin_oe,
   input wire logic adv_pin_is_setup,
   input wire logic irq_request,
   input wire logic power_down_enable,
   input wire logic ext_power_down_n,
   output logic data_buffer_enable_n,
   output logic data_buffer_direction,
   output logic [MA_WIDTH-1:0] shared_mem_addr_out,
   output logic [MA_WIDTH-1:0] shared_mem_addr_oe,
   output logic [3:0] dma_ack_lines_out,
   output logic [3:0] dma_ack_lines_oe,
   output logic sram_read_strobe,
   output logic sram_write_strobe,
   output logic cfg_reg_sel_valid,
   output logic [irhp_pkg::SA_W-1:0] cfg_reg_index,
   output logic power_down_req,
   output irhp_pkg::irhp_mode_s mode_now
);

   // pin map and dma float mask are fixed at fifteen bits
   if (MA_WIDTH != irhp_pkg::MA_W) begin : g_bad_width
      $error("MA_WIDTH must be 15");
   end

   logic [2:0] mode_ff;
   logic buf_en_ff;
   logic buf_dir_ff;
   logic [MA_WIDTH-1:0] ma_ff;
   logic [MA_WIDTH-1:0] ma_oe_ff;
   logic [3:0] ack_ff;
   logic [3:0] ack_oe_ff;
   logic mrd_ff;
   logic mwr_ff;
   logic sel_ff;
   logic [2:0] idx_ff;
   logic pd_ff;
   logic irq_ff;
   logic irq_oe_ff;

   wire logic shm;
   wire logic dma;
   wire irhp_pkg::irhp_cfg_e cfg;
   wire logic setup_fn;
   wire logic mem_rd;
   wire logic mem_wr;
   wire logic setup_act;
   wire logic nxt_buf_en;
   wire logic nxt_buf_dir;
   wire logic [MA_WIDTH-1:0] nxt_ma_oe;
   wire logic nxt_sel;
   wire logic nxt_pd;

   // straps caught by a clocked process, never by reset
   always_ff @(posedge core_clk) begin
      mode_ff <= bus_config_select;
   end

   // mode decode; reserved codes enable neither memory scheme
   assign shm = (mode_ff == irhp_pkg::MODE_DIR_SHM) || (mode_ff == irhp_pkg::MODE_IND_SHM)
      || (mode_ff == irhp_pkg::MODE_PNP_SHM);
   assign dma = (mode_ff == irhp_pkg::MODE_DIR_DMA) || (mode_ff == irhp_pkg::MODE_IND_DMA)
      || (mode_ff == irhp_pkg::MODE_PNP_DMA);
   assign cfg = (shm || dma) ? ((mode_ff[2]) ? irhp_pkg::IRHP_CFG_PNP
      : (mode_ff[1]) ? irhp_pkg::IRHP_CFG_INDIRECT : irhp_pkg::IRHP_CFG_DIRECT)
      : irhp_pkg::IRHP_CFG_RESERVED;
   assign mode_now = '{cfg: cfg, shared_mem: shm, host_dma: dma};

   // strobes count only in shared memory mode
   assign mem_rd = shm && !host_mem_read_n && host_cycle.mem_window_hit;
   assign mem_wr = shm && !host_mem_write_n && host_cycle.mem_window_hit;

   // pin role: direct always setup, pnp always irq, indirect by setting
   assign setup_fn = (cfg == irhp_pkg::IRHP_CFG_DIRECT)
      || ((cfg == irhp_pkg::IRHP_CFG_INDIRECT) && adv_pin_is_setup);
   assign setup_act = setup_fn && !irq_or_cfg_select_pin_in;

   // buffer enable: host access, dma in dma mode, sram access; else high
   assign nxt_buf_en = host_cycle.io_access || (dma && host_cycle.dma_access)
      || mem_rd || mem_wr;
   // direction on host i/o reads, dma reads in dma mode and sram reads
   assign nxt_buf_dir = (host_cycle.io_access && host_cycle.io_read)
      || (dma && host_cycle.dma_access && host_cycle.dma_read) || mem_rd;
   // host dma mode floats low and middle address bits
   assign nxt_ma_oe = shm ? {MA_WIDTH{1'b1}} : dma ? ~irhp_pkg::MA_DMA_TRI_MASK
      : '0;
   // setup decode of the low address bits
   assign nxt_sel = setup_act && host_cycle.io_access;
   // power down honoured only once enabled
   assign nxt_pd = power_down_enable && !ext_power_down_n;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         buf_en_ff <= 1'b0;
         buf_dir_ff <= 1'b0;
         ma_ff <= irhp_pkg::MA_RST;
         ma_oe_ff <= '0;
         ack_ff <= 4'h0;
         ack_oe_ff <= 4'h0;
         mrd_ff <= 1'b0;
         mwr_ff <= 1'b0;
         sel_ff <= 1'b0;
         idx_ff <= irhp_pkg::CFG_IDX_RST;
         pd_ff <= 1'b0;
         irq_ff <= 1'b0;
         irq_oe_ff <= 1'b0;
      end else begin
         buf_en_ff <= nxt_buf_en;
         buf_dir_ff <= nxt_buf_dir;
         ma_ff <= shm ? sram_addr : '0;
         ma_oe_ff <= nxt_ma_oe;
         ack_ff <= shm ? sram_addr[irhp_pkg::ACK_HI:irhp_pkg::ACK_LO] : 4'h0;
         ack_oe_ff <= shm ? 4'hF : 4'h0;
         mrd_ff <= mem_rd;
         mwr_ff <= mem_wr;
         sel_ff <= nxt_sel;
         idx_ff <= nxt_sel ? host_cycle.addr_lo : idx_ff;
         pd_ff <= nxt_pd;
         irq_ff <= irq_request;
         irq_oe_ff <= !setup_fn;
      end
   end

   assign data_buffer_enable_n = !buf_en_ff;
   assign data_buffer_direction = buf_dir_ff;
   assign shared_mem_addr_out = ma_ff;
   assign shared_mem_addr_oe = ma_oe_ff;
   assign dma_ack_lines_out = ack_ff;
   assign dma_ack_lines_oe = ack_oe_ff;
   assign sram_read_strobe = mrd_ff;
   assign sram_write_strobe = mwr_ff;
   assign cfg_reg_sel_valid = sel_ff;
   assign cfg_reg_index = idx_ff;
   assign power_down_req = pd_ff;
   assign irq_or_cfg_select_pin_out = irq_ff;
   assign irq_or_cfg_select_pin_oe = irq_oe_ff;

   AST_BUF_ON_IO: assert property (@(posedge core_clk) disable iff (srst)
      host_cycle.io_access |=> !data_buffer_enable_n)
      else $error("buffer enable missing on host access");

   AST_BUF_SHM: assert property (@(posedge core_clk) disable iff (srst)
      (shm && !host_mem_read_n && host_cycle.mem_window_hit) |=> !data_buffer_enable_n)
      else $error("buffer enable missing on sram access");

   AST_BUF_IDLE: assert property (@(posedge core_clk) disable iff (srst)
      (!host_cycle.io_access && !host_cycle.dma_access && host_mem_read_n
      && host_mem_write_n) |=> data_buffer_enable_n)
      else $error("buffer enable active on idle cycle");

   AST_DMA_TRI: assert property (@(posedge core_clk) disable iff (srst)
      dma |=> (shared_mem_addr_oe[3:0] == 4'h0) && (shared_mem_addr_oe[10:8] == 3'h0))
      else $error("address bits driven in host dma mode");

   AST_SHM_ADDR: assert property (@(posedge core_clk) disable iff (srst)
      shm |=> (shared_mem_addr_out == $past(sram_addr)) && (&shared_mem_addr_oe))
      else $error("shared memory address not driven");

   AST_STROBE_GATE: assert property (@(posedge core_clk) disable iff (srst)
      !shm |=> !sram_read_strobe && !sram_write_strobe)
      else $error("memory strobe used outside shared mode");

   AST_SETUP_SEL: assert property (@(posedge core_clk) disable iff (srst)
      (setup_act && host_cycle.io_access) |=>
      cfg_reg_sel_valid && (cfg_reg_index == $past(host_cycle.addr_lo)))
      else $error("setup decode wrong");

   AST_PNP_IRQ: assert property (@(posedge core_clk) disable iff (srst)
      (cfg == irhp_pkg::IRHP_CFG_PNP) |=> irq_or_cfg_select_pin_oe && !cfg_reg_sel_valid)
      else $error("pin not an irq in pnp mode");

   AST_DIR_READ: assert property (@(posedge core_clk) disable iff (srst)
      (host_cycle.io_access && host_cycle.io_read) |=> data_buffer_direction)
      else $error("direction not active on read");

   AST_ACK_ADDR: assert property (@(posedge core_clk) disable iff (srst)
      shm |=> dma_ack_lines_out == $past(sram_addr[7:4]))
      else $error("ack pins not carrying address");

   AST_PWR: assert property (@(posedge core_clk) disable iff (srst)
      (power_down_enable && !ext_power_down_n) |=> power_down_req)
      else $error("power down not requested");

   AST_WR_STROBE: assert property (@(posedge core_clk) disable iff (srst)
      (shm && !host_mem_write_n && host_cycle.mem_window_hit) |=>
      sram_write_strobe && !data_buffer_enable_n)
      else $error("sram write strobe missing");

   AST_ACK_FLOAT: assert property (@(posedge core_clk) disable iff (srst)
      dma |=> (dma_ack_lines_oe == 4'h0))
      else $error("ack pins driven in host dma mode");

   AST_IND_PIN: assert property (@(posedge core_clk) disable iff (srst)
      ((cfg == irhp_pkg::IRHP_CFG_INDIRECT) && !adv_pin_is_setup) |=> irq_or_cfg_select_pin_oe)
      else $error("pin not an irq in indirect mode");

   AST_DIR_SETUP: assert property (@(posedge core_clk) disable iff (srst)
      (cfg == irhp_pkg::IRHP_CFG_DIRECT) |=> !irq_or_cfg_select_pin_oe)
      else $error("setup pin driven in direct mode");

endmodule

// >>> irhp_host_model.sv
/*
 host side model: turns a random word into legal host bus activity.
 assumes the bench changes rnd away from the sampling clock edge.
*/
`timescale 1ns/1ps
module irhp_host_model (
   input wire logic [31:0] rnd,
   output irhp_pkg::irhp_cycle_s cyc,
   output logic mem_read_n,
   output logic mem_write_n,
   output logic setup_n,
   output logic pd_enable,
   output logic pd_n
);
   logic io;
   logic mem_rd;
   assign io = rnd[0] & ~rnd[2];
   assign cyc = {io, rnd[1], rnd[2], rnd[3], rnd[4], rnd[7:5]};
   assign mem_rd = rnd[8] & ~io;
   // strobes low only in memory cycles
   assign mem_read_n = ~mem_rd;
   assign mem_write_n = ~(rnd[9] & ~mem_rd & ~io);
   assign setup_n = ~(io & rnd[10]);
   assign pd_enable = rnd[11];
   assign pd_n = ~(rnd[11] & rnd[12]);
endmodule

// >>> irhp_pin_ctrl_tb.sv
/*
 self-checking bench for the host bus pin control block.
 assumes registered outputs one cycle after the inputs; inputs change on falling edges.
*/
`timescale 1ns/1ps
module irhp_pin_ctrl_tb;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [2:0] mode_sel = 3'h0;
   logic [31:0] rnd = 32'h0;
   logic [31:0] seed = 32'h49;
   logic [14:0] addr = 15'h0000;
   logic adv = 1'b0;
   logic irq = 1'b0;
   irhp_pkg::irhp_cycle_s cyc;
   irhp_pkg::irhp_mode_s mode_now;
   logic rd_n, wr_n, setup_n, pd_en, pd_n, pin_wire, pin_out, pin_oe;
   logic en_n, dir, rs, ws, sel_v, pd_req;
   logic [2:0] idx;
   logic [14:0] ma, ma_oe;
   logic [3:0] ack, ack_oe;
   int err_count = 0;
   int compares = 0;
   int last_idx = 0;
   always #5 core_clk = ~core_clk;
   // wire level of the shared irq/setup pin
   assign pin_wire = pin_oe ? pin_out : setup_n;
   irhp_host_model host (.rnd(rnd), .cyc(cyc), .mem_read_n(rd_n), .mem_write_n(wr_n),
      .setup_n(setup_n), .pd_enable(pd_en), .pd_n(pd_n));
   irhp_pin_ctrl #(.MA_WIDTH(15)) dut (.core_clk(core_clk), .srst(srst),
      .bus_config_select(mode_sel), .host_cycle(cyc), .host_mem_read_n(rd_n),
      .host_mem_write_n(wr_n), .sram_addr(addr), .irq_or_cfg_select_pin_in(pin_wire),
      .irq_or_cfg_select_pin_out(pin_out), .irq_or_cfg_select_pin_oe(pin_oe),
      .adv_pin_is_setup(adv), .irq_request(irq), .power_down_enable(pd_en),
      .ext_power_down_n(pd_n), .data_buffer_enable_n(en_n), .data_buffer_direction(dir),
      .shared_mem_addr_out(ma), .shared_mem_addr_oe(ma_oe), .dma_ack_lines_out(ack),
      .dma_ack_lines_oe(ack_oe), .sram_read_strobe(rs), .sram_write_strobe(ws),
      .cfg_reg_sel_valid(sel_v), .cfg_reg_index(idx), .power_down_req(pd_req),
      .mode_now(mode_now));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("mismatches %0d, comparisons %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // reference model of one bus cycle
   task automatic check_cycle();
      int m, shm, dma, cfg, hit, mr, mw, io, pin_setup, setup;
      m = mode_sel;
      shm = (m == 1 || m == 3 || m == 6);
      dma = (m == 0 || m == 2 || m == 4);
      cfg = (m < 2) ? 0 : (m < 4) ? 1 : (m == 4 || m == 6) ? 2 : 3;
      hit = shm && cyc.mem_window_hit;
      mr = hit && !rd_n;
      mw = hit && !wr_n;
      io = cyc.io_access;
      pin_setup = (cfg == 0) || (cfg == 1 && adv);
      setup = pin_setup && io && !setup_n;
      if (setup) begin
         last_idx = cyc.addr_lo;
      end
      chk(mode_now, (cfg << 2) | (shm << 1) | dma);
      chk(en_n, !(io || (dma && cyc.dma_access) || mr || mw));
      chk(dir, (io && cyc.io_read) || (dma && cyc.dma_access && cyc.dma_read) || mr);
      chk({rs, ws}, mr * 2 + mw);
      chk({sel_v, idx}, setup * 8 + last_idx);
      chk(ma_oe & irhp_pkg::MA_DMA_TRI_MASK, shm ? irhp_pkg::MA_DMA_TRI_MASK : 0);
      chk(pd_req, pd_en && !pd_n);
      if (shm) begin
         chk({ma, ma_oe}, {addr, 15'h7FFF});
         chk({ack, ack_oe}, {addr[7:4], 4'hF});
      end else begin
         chk(ack_oe, 0);
      end
      if (mr || mw) begin
         chk(en_n, 0);
      end
      if (!pin_setup) begin
         chk({pin_oe, pin_out}, 2 + irq);
      end
      if (pin_setup) begin
         chk(pin_oe, 0);
      end
   endtask
   initial begin
      repeat (20) @(negedge core_clk);
      chk({en_n, pd_req, ma_oe}, 32'h10000);
      srst = 1'b0;
      // pin role held per run: its drive turns over two edges after a mode change
      for (int m = 0; m < 16; m++) begin
         mode_sel = m[3:1];
         adv = m[0];
         repeat (3) @(negedge core_clk);
         for (int i = 0; i < 30; i++) begin
            seed = xs(seed);
            rnd = seed;
            irq = seed[21];
            addr = seed[30:16];
            @(negedge core_clk);
            check_cycle();
         end
      end
      test_done();
   end
   initial begin
      #100000;
      err_count++;
      test_done();
   end
endmodule
